//--- src/bvm_pkg.sv
package bvm_pkg;

  // ----------------------------------------------------------------
  // Address widths
  // ----------------------------------------------------------------
  localparam int PROC_AW = 36;
  localparam int PORT_AW = 32;

  // ----------------------------------------------------------------
  // Boot vector and presented addresses
  // ----------------------------------------------------------------
  localparam logic [35:0] BOOT_VECTOR    = 36'h0_FFF0_0100;
  localparam logic [31:0] ADDR_DEFAULT   = 32'h0000_0100;
  localparam logic [31:0] ADDR_RELOCATED = 32'h00F0_0100;
  localparam logic [31:0] ADDR_LATCHED   = 32'h0FF0_0100;
  localparam logic [31:0] MASK_24        = 32'h00FF_FFFF;

  // Boot window span: upper 1 MiB region of the 4 GiB space, bank 0
  localparam logic [35:0] BOOT_WIN_BASE  = 36'h0_FFF0_0000;
  localparam logic [35:0] BOOT_WIN_MASK  = 36'hF_FFF0_0000;

  // ----------------------------------------------------------------
  // Window enable field positions and reset value
  // ----------------------------------------------------------------
  localparam int NUM_WIN      = 8;
  localparam int WIN_PROC1    = 0;
  localparam int WIN_CS0      = 1;
  localparam int WIN_CS1      = 2;
  localparam logic [7:0] WIN_EN_RESET = 8'h07;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    logic [35:0] addr;
  } bvm_req_s;

  typedef struct packed {
    logic        valid;
    logic        cs0;
    logic        miss;
    logic        wide;
    logic [31:0] addr;
  } bvm_port_s;

  typedef struct packed {
    logic        vsel;
    logic        latch;
    logic        boot_en;
    logic [7:0]  win_en;
    bvm_port_s   port;
  } bvm_state_s;

endpackage

//--- src/bvm_boot_map.sv
`timescale 1ns/1ps
`default_nettype none
module bvm_boot_map
  import bvm_pkg::*;
(
  // Clock and reset
  input  wire logic      clk,
  input  wire logic      reset,
  // Power-up straps
  input  wire logic      vector_select_strap,
  input  wire logic      latched_address_strap,
  // Processor fetch request
  input  wire bvm_req_s  proc_req,
  // Peripheral port side
  output var  bvm_port_s local_peripheral_port,
  // Window status
  output logic [7:0]     win_enable,
  output logic           processor_outbound_window_1
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  bvm_state_s state_reg;
  bvm_state_s state_next;

  // Does the fetch fall in the default boot window span
  function automatic logic in_boot_win(input logic [35:0] a);
    in_boot_win = ((a & BOOT_WIN_MASK) == BOOT_WIN_BASE);
  endfunction

  // A fetch hits when the boot window and chip select 0 are both
  // enabled and the address falls in the boot span
  function automatic logic boot_hit(input bvm_state_s st,
                                    input logic [35:0] a);
    boot_hit = st.boot_en && st.win_en[WIN_PROC1] && st.win_en[WIN_CS0]
               && in_boot_win(a);
  endfunction

  // Presented address by strap; latched mode takes priority as the
  // port then drives the full 32-bit address
  function automatic logic [31:0] map_addr(input logic [35:0] a,
                                           input logic vs,
                                           input logic la);
    logic [31:0] low;
    low = a[31:0];
    // Latched mode replaces the whole upper 12 bits, not only a nibble
    if (la)
      map_addr = (low & 32'h000F_FFFF) | (ADDR_LATCHED & 32'hFFF0_0000);
    else if (vs)
      map_addr = (low & MASK_24) | (ADDR_RELOCATED & 32'h00F0_0000);
    else
      map_addr = low & 32'h000F_FFFF;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Straps only move while reset is held, so a strap glitch later
  // cannot remap the boot device under a running processor
  always_comb begin
    state_next = state_reg;
    state_next.port.valid = 1'b0;
    state_next.port.cs0   = 1'b0;
    state_next.port.miss  = 1'b0;
    if (reset) begin
      state_next.vsel    = vector_select_strap;
      state_next.latch   = latched_address_strap;
      state_next.boot_en = 1'b1;
      state_next.win_en  = WIN_EN_RESET;
      state_next.port    = '0;
    end else if (proc_req.valid) begin
      state_next.port.valid = 1'b1;
      if (boot_hit(state_reg, proc_req.addr)) begin
        state_next.port.cs0  = 1'b1;
        state_next.port.wide = state_reg.latch;
        state_next.port.addr = map_addr(proc_req.addr,
                                        state_reg.vsel,
                                        state_reg.latch);
      end else begin
        state_next.port.miss = 1'b1;
        state_next.port.addr = '0;
      end
    end
  end

  // Registered state
  always_ff @(posedge clk) begin
    state_reg <= state_next;
  end

  // ----------------------------------------------------------------
  // Outputs straight from flops
  // ----------------------------------------------------------------
  // No write path in this block: the windows keep their reset
  // values, so software cannot open further windows through it
  assign local_peripheral_port       = state_reg.port;
  assign win_enable                  = state_reg.win_en;
  assign processor_outbound_window_1 = state_reg.boot_en;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_reset_windows: assert property (@(posedge clk)
    $fell(reset) |-> win_enable == WIN_EN_RESET)
    else $error("window enables wrong after reset");

  a_boot_bit_set: assert property (@(posedge clk)
    $fell(reset) |-> processor_outbound_window_1)
    else $error("boot enable not set after reset");

  a_cs_enabled: assert property (@(posedge clk)
    $fell(reset) |-> win_enable[WIN_CS0] && win_enable[WIN_CS1])
    else $error("chip select windows not enabled");

  a_default_map: assert property (@(posedge clk) disable iff (reset)
    proc_req.valid && proc_req.addr == BOOT_VECTOR
    && !state_reg.vsel && !state_reg.latch
    |=> local_peripheral_port.cs0
        && local_peripheral_port.addr == ADDR_DEFAULT)
    else $error("default boot vector mapped wrong");

  a_reloc_map: assert property (@(posedge clk) disable iff (reset)
    proc_req.valid && proc_req.addr == BOOT_VECTOR
    && state_reg.vsel && !state_reg.latch
    |=> local_peripheral_port.cs0
        && local_peripheral_port.addr == ADDR_RELOCATED)
    else $error("relocated boot vector mapped wrong");

  a_latched_map: assert property (@(posedge clk) disable iff (reset)
    proc_req.valid && proc_req.addr == BOOT_VECTOR && state_reg.latch
    |=> local_peripheral_port.wide
        && local_peripheral_port.addr == ADDR_LATCHED)
    else $error("latched boot vector mapped wrong");

  a_strap_hold: assert property (@(posedge clk) disable iff (reset)
    ##1 !$past(reset) |-> $stable(state_reg.vsel)
                          && $stable(state_reg.latch))
    else $error("strap sample changed outside reset");

  a_miss_no_cs: assert property (@(posedge clk) disable iff (reset)
    proc_req.valid && !in_boot_win(proc_req.addr)
    |=> local_peripheral_port.miss && !local_peripheral_port.cs0)
    else $error("fetch outside window reached chip select");

  // ----------------------------------------------------------------
  // Checks on answer timing
  // ----------------------------------------------------------------
  // Every taken fetch answers exactly one cycle later, hit or miss
  a_answer_next: assert property (@(posedge clk) disable iff (reset)
    proc_req.valid |=> local_peripheral_port.valid)
    else $error("taken fetch gave no answer next cycle");

  // Without a fetch the strobes stay low; a stuck strobe would make
  // the boot device see a second access that nobody asked for
  a_idle_quiet: assert property (@(posedge clk) disable iff (reset)
    !proc_req.valid
    |=> !local_peripheral_port.valid && !local_peripheral_port.cs0
        && !local_peripheral_port.miss)
    else $error("port strobe raised without a fetch");

  // Address and width hold between fetches for a slow boot device
  a_addr_hold: assert property (@(posedge clk) disable iff (reset)
    !proc_req.valid
    |=> $stable(local_peripheral_port.addr)
        && $stable(local_peripheral_port.wide))
    else $error("port address moved without a fetch");

  // ----------------------------------------------------------------
  // Checks on the mapping of any fetch inside the boot window, and of a refused fetch
  // ----------------------------------------------------------------
  // The low 20 bits pass through in every strap setting
  a_low_bits: assert property (@(posedge clk) disable iff (reset)
    proc_req.valid && boot_hit(state_reg, proc_req.addr)
    |=> local_peripheral_port.cs0
        && local_peripheral_port.addr[19:0] == $past(proc_req.addr[19:0]))
    else $error("low address bits not passed to chip select 0");

  a_default_top: assert property (@(posedge clk) disable iff (reset)
    proc_req.valid && boot_hit(state_reg, proc_req.addr)
    && !state_reg.vsel && !state_reg.latch
    |=> local_peripheral_port.addr[31:20] == ADDR_DEFAULT[31:20]
        && !local_peripheral_port.wide)
    else $error("default mapping set upper address bits");

  a_reloc_top: assert property (@(posedge clk) disable iff (reset)
    proc_req.valid && boot_hit(state_reg, proc_req.addr)
    && state_reg.vsel && !state_reg.latch
    |=> local_peripheral_port.addr[31:20] == ADDR_RELOCATED[31:20]
        && !local_peripheral_port.wide)
    else $error("relocated mapping upper address bits wrong");

  // Latched mode wins over relocation when both straps are set
  a_latch_top: assert property (@(posedge clk) disable iff (reset)
    proc_req.valid && boot_hit(state_reg, proc_req.addr) && state_reg.latch
    |=> local_peripheral_port.addr[31:20] == ADDR_LATCHED[31:20]
        && local_peripheral_port.wide)
    else $error("latched mapping upper address bits wrong");

  // A refused fetch drives no address at all
  a_miss_addr: assert property (@(posedge clk) disable iff (reset)
    proc_req.valid && !boot_hit(state_reg, proc_req.addr)
    |=> local_peripheral_port.addr == 32'h0000_0000)
    else $error("refused fetch drove an address");

  // ----------------------------------------------------------------
  // Checks on the reset state
  // ----------------------------------------------------------------
  // The port comes out of reset with every strobe and address low
  a_port_reset: assert property (@(posedge clk)
    $fell(reset) |-> local_peripheral_port == '0)
    else $error("port not cleared by reset");

  // Each edge under reset takes the strap levels seen at that edge
  a_strap_taken: assert property (@(posedge clk)
    reset |=> state_reg.vsel == $past(vector_select_strap)
              && state_reg.latch == $past(latched_address_strap))
    else $error("strap level not captured under reset");

endmodule // bvm_boot_map
`default_nettype wire

//--- sim/bvm_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Processor core fetching its boot vector
// ----------------------------------------
module bvm_cpu_model
  import bvm_pkg::*;
(
  // Clock and fetch request
  input  wire logic     clk,
  output var  bvm_req_s req
);
  initial req = '0;
  // One fetch per falling edge, taken at the next rising edge
  task automatic fetch(input logic [35:0] a);
    @(negedge clk);
    req.valid = 1'b1;
    req.addr  = a;
  endtask
  // Idle bus shows an inverted address so no stale value looks valid
  task automatic idle();
    @(negedge clk);
    req.valid = 1'b0;
    req.addr  = ~req.addr;
  endtask
endmodule // bvm_cpu_model
`default_nettype wire

//--- sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Boot map bench
// ----------------------------------------
module tb_top;
  import bvm_pkg::*;
  logic        clk = 0, reset = 1, vs = 0, la = 0, mv = 0, ml = 0;
  bvm_req_s    req;
  bvm_port_s   port;
  logic [7:0]  win;
  logic        boot;
  logic [31:0] rng = 32'h8FC9_8AA3;
  logic [35:0] pend = '0, due = '0, s;
  int          fails = 0, n_tests = 0, cyc = 0;
  always #4 clk = ~clk;
  bvm_cpu_model i_cpu (.clk(clk), .req(req));
  bvm_boot_map i_dut (.clk(clk), .reset(reset), .vector_select_strap(vs),
    .latched_address_strap(la), .proc_req(req),
    .local_peripheral_port(port), .win_enable(win),
    .processor_outbound_window_1(boot));
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    if (fails == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Expected port word {valid,cs0,miss,wide,addr}; wide unspecified on miss
  function automatic logic [35:0] model(input logic [35:0] a);
    logic [31:0] o;
    if (a[35:20] != 16'h0FFF) return {4'hA, 32'h0};
    o = {12'h000, a[19:0]};
    if (ml) o[31:20] = 12'h0FF;
    else if (mv) o[23:20] = 4'hF;
    return {3'b110, ml, o};
  endfunction
  task automatic go(input logic [35:0] a);
    i_cpu.fetch(a);
    pend = reset ? '0 : model(a);
  endtask
  // Monitor after each rising edge; answer due exactly one cycle later
  always @(posedge clk) begin
    #1;
    cyc++;
    if (reset) {mv, ml} = {vs, la};
    due = pend;
    pend = '0;
    s = port;
    if (!due[35]) s[32:0] = '0;
    if (due[33]) s[32] = 1'b0;
    check(s, due);
    check({27'h0, win, boot}, {27'h0, WIN_EN_RESET, 1'b1});
    if (cyc > 1000) begin
      fails++;
      wrap_up();
    end
  end
  // Each strap pairing, with a fetch under reset and straps flipped after
  initial begin
    for (int m = 0; m < 4; m++) begin
      @(negedge clk);
      reset = 1;
      {la, vs} = m[1:0];
      go(BOOT_VECTOR);
      i_cpu.idle();
      @(negedge clk);
      reset = 0;
      {la, vs} = ~m[1:0];
      go(BOOT_VECTOR);
      go(BOOT_VECTOR);
      go(36'h0_FFEF_FFFF);
      go(36'h0_FFFF_FFFF);
      go(36'h1_FFF0_0100);
      for (int i = 0; i < 16; i++) begin
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        go(i[0] ? {16'h0FFF, rng[19:0]} : {rng[3:0], rng});
      end
      i_cpu.idle();
    end
    repeat (3) @(negedge clk);
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire
